// ---- core/abeu_pkg.sv ----
// Notes on behaviour
// (RQ1) Add two registers, optionally plus carry, in one cycle; Z C N V H updated.
// (RQ2) Subtract register or constant, optionally with borrow, one cycle; Z C N V H updated.
// (RQ3) Word add/subtract immediate on a register pair over two cycles; Z C N V S updated.
// (RQ4) AND, OR, XOR with register or constant in one cycle; only Z N V S updated.
// (RQ5) Clear-bits ANDs with 0xFF minus constant; set-bits ORs it in; Z N V.
// (RQ6) Zero/sign test ANDs a register with itself; Z N V from the result.
// (RQ7) Unsigned, signed, mixed 8x8 products go to r1:r0 in two cycles; Z C.
// (RQ8) Fractional products are shifted left one before r1:r0; two cycles; Z C.
// (RQ9) Jump via pointer loads PC from Z pointer in two cycles; no flags.
// (RQ10) Call via pointer saves return address, loads PC from Z; three cycles.
// (RQ11) Skip-if-equal skips next instruction when registers match; 1/2/3 cycles.
// (RQ12) Compares compute the difference without write-back; Z N V C H updated.
// (RQ13) Register-bit skips test one bit for clear or set; 1/2/3 cycles.
// (RQ14) I/O-bit skips test one I/O register bit for clear or set; 1/2/3 cycles.
// (RQ15) Flag branches test any status bit; taken loads PC+offset+1; 1/2 cycles. The code tests N xor V instead of the stored S bit.
// (RQ16) Signed not-less taken on N xor V = 0; signed less on 1.
// (RQ17) Unsigned not-lower taken on carry clear; lower taken on carry set.
// (RQ18) Branches on half-carry set and clear, same relative target.
// (RQ19) Branches on overflow set and clear, same relative target.
// (RQ20) Branches on transfer flag set and clear, same relative target.
// (RQ21) Branches on interrupt enable set and clear, same relative target.
// (RQ22) Branch: 1 cycle not taken, 2 taken; skip 1, or 2/3 by skipped length.
package abeu_pkg;
	// Status bit positions
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] MASK_ALL = 8'hFF;
	// Cycle counts
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;
	localparam logic [15:0] SKIP_SHORT = 16'h0002;
	localparam logic [15:0] SKIP_LONG = 16'h0003;
	localparam logic [15:0] PC_STEP = 16'h0001;

	typedef enum logic [4:0] {
		OP_ADD = 5'h00,
		OP_ADD_CARRY = 5'h01,
		OP_SUB = 5'h02,
		OP_SUB_BORROW = 5'h03,
		OP_WORD_PLUS_IMM = 5'h04,
		OP_WORD_MINUS_IMM = 5'h05,
		OP_AND = 5'h06,
		OP_OR = 5'h07,
		OP_XOR = 5'h08,
		OP_SET_BITS = 5'h09,
		OP_CLEAR_BITS = 5'h0A,
		OP_ZERO_SIGN_TEST = 5'h0B,
		OP_PROD_U = 5'h0C,
		OP_PROD_S = 5'h0D,
		OP_PROD_SU = 5'h0E,
		OP_FRAC_U = 5'h0F,
		OP_FRAC_S = 5'h10,
		OP_FRAC_SU = 5'h11,
		OP_JUMP_PTR = 5'h12,
		OP_CALL_PTR = 5'h13,
		OP_SKIP_EQUAL = 5'h14,
		OP_COMPARE = 5'h15,
		OP_COMPARE_BORROW = 5'h16,
		OP_SKIP_REG_CLR = 5'h17,
		OP_SKIP_REG_SET = 5'h18,
		OP_SKIP_IO_CLR = 5'h19,
		OP_SKIP_IO_SET = 5'h1A,
		OP_BRANCH_SET = 5'h1B,
		OP_BRANCH_CLR = 5'h1C
	} abeu_op_t;
endpackage : abeu_pkg

// ---- core/abeu_mul_if.sv ----
`timescale 1ns/1ps
interface abeu_mul_if;
	logic [7:0] mulA;
	logic [7:0] mulB;
	logic signedA;
	logic signedB;
	logic fraction;
	logic [15:0] product;
	logic productZero;
	logic productCarry;
	modport requester (output mulA, mulB, signedA, signedB, fraction, input product, productZero, productCarry);
	modport multiplier (input mulA, mulB, signedA, signedB, fraction, output product, productZero, productCarry);
endinterface : abeu_mul_if

// ---- core/abeu_multiplier.sv ----
`timescale 1ns/1ps
module abeu_multiplier (
	abeu_mul_if.multiplier mul
);
	logic signed [8:0] extA;
	logic signed [8:0] extB;
	logic signed [17:0] fullProduct;
	logic [15:0] rawProduct;

	// Sign extension per operand covers the unsigned, signed and mixed forms
	assign extA = {mul.signedA & mul.mulA[7], mul.mulA};
	assign extB = {mul.signedB & mul.mulB[7], mul.mulB};
	assign fullProduct = extA * extB;
	assign rawProduct = fullProduct[15:0];
	// Carry is taken before the fractional shift so the dropped top bit is kept
	assign mul.productCarry = rawProduct[15]; // RQ7
	assign mul.product = mul.fraction ? {rawProduct[14:0], 1'b0} : rawProduct; // RQ8
	assign mul.productZero = (mul.product == 16'h0000); // RQ7
endmodule : abeu_multiplier

// ---- core/abeu_exec_unit.sv ----
`timescale 1ns/1ps
module abeu_exec_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Request from decoder
	input wire logic start,
	input wire abeu_pkg::abeu_op_t op,
	input wire logic [7:0] destVal,
	input wire logic [7:0] source_register,
	input wire logic [15:0] pairVal,
	input wire logic [2:0] bitSel,
	input wire logic [7:0] ioByte,
	input wire logic [6:0] branchOffset,
	input wire logic nextIsTwoWords,
	input wire logic [15:0] pcIn,
	input wire logic [15:0] zPointer,
	// Status load from other instruction groups
	input wire logic flagLoad,
	input wire logic [7:0] flagLoadVal,
	// Handshake
	output logic ready,
	output logic done,
	// Register file write-back
	output logic byteWrite,
	output logic [7:0] byteResult,
	output logic pairWrite,
	output logic pairToProduct,
	output logic [15:0] pairResult,
	// Program flow
	output logic pcLoad,
	output logic [15:0] pcTarget,
	output logic pushReturn,
	output logic [15:0] returnAddr,
	// Status
	output logic [7:0] status_flags_register
);
	abeu_mul_if mulBus ();

	logic take;
	logic [1:0] remFf;
	logic [1:0] nxt_rem;
	logic doneFf;
	logic byteWrFf;
	logic pairWrFf;
	logic prodDestFf;
	logic pcLoadFf;
	logic pushFf;
	logic [7:0] byteResFf;
	logic [15:0] pairResFf;
	logic [15:0] pcTargetFf;
	logic [15:0] returnAddrFf;
	logic [7:0] statusFf;
	logic [7:0] nxt_status;

	// Operation classes
	logic isAdd;
	logic isSubLike;
	logic isCompare;
	logic isLogic;
	logic isWord;
	logic isMul;
	logic isBranch;
	logic isSkip;
	logic useCarry;
	logic chainZero;

	assign isAdd = (op == abeu_pkg::OP_ADD) || (op == abeu_pkg::OP_ADD_CARRY);
	assign isCompare = (op == abeu_pkg::OP_COMPARE) || (op == abeu_pkg::OP_COMPARE_BORROW);
	assign isSubLike = (op == abeu_pkg::OP_SUB) || (op == abeu_pkg::OP_SUB_BORROW) || isCompare;
	assign isLogic = (op == abeu_pkg::OP_AND) || (op == abeu_pkg::OP_OR) || (op == abeu_pkg::OP_XOR)
		|| (op == abeu_pkg::OP_SET_BITS) || (op == abeu_pkg::OP_CLEAR_BITS)
		|| (op == abeu_pkg::OP_ZERO_SIGN_TEST);
	assign isWord = (op == abeu_pkg::OP_WORD_PLUS_IMM) || (op == abeu_pkg::OP_WORD_MINUS_IMM);
	assign isMul = (op == abeu_pkg::OP_PROD_U) || (op == abeu_pkg::OP_PROD_S) || (op == abeu_pkg::OP_PROD_SU)
		|| (op == abeu_pkg::OP_FRAC_U) || (op == abeu_pkg::OP_FRAC_S) || (op == abeu_pkg::OP_FRAC_SU);
	assign isBranch = (op == abeu_pkg::OP_BRANCH_SET) || (op == abeu_pkg::OP_BRANCH_CLR);
	assign isSkip = (op == abeu_pkg::OP_SKIP_EQUAL) || (op == abeu_pkg::OP_SKIP_REG_CLR)
		|| (op == abeu_pkg::OP_SKIP_REG_SET) || (op == abeu_pkg::OP_SKIP_IO_CLR)
		|| (op == abeu_pkg::OP_SKIP_IO_SET);
	assign useCarry = (op == abeu_pkg::OP_ADD_CARRY) || (op == abeu_pkg::OP_SUB_BORROW)
		|| (op == abeu_pkg::OP_COMPARE_BORROW);
	// Borrow variants keep Z only if it was already set, so multi-byte compares chain
	assign chainZero = (op == abeu_pkg::OP_SUB_BORROW) || (op == abeu_pkg::OP_COMPARE_BORROW);

	// Byte adder and subtractor
	logic carryIn;
	logic [4:0] addNib;
	logic [8:0] addSum;
	logic [4:0] subNib;
	logic [8:0] subDiff;
	logic addOvf;
	logic subOvf;

	assign carryIn = useCarry & statusFf[abeu_pkg::FLAG_C]; // RQ1 RQ2
	assign addNib = {1'b0, destVal[3:0]} + {1'b0, source_register[3:0]} + {4'h0, carryIn};
	assign addSum = {1'b0, destVal} + {1'b0, source_register} + {8'h00, carryIn}; // RQ1
	assign subNib = {1'b0, destVal[3:0]} - {1'b0, source_register[3:0]} - {4'h0, carryIn};
	assign subDiff = {1'b0, destVal} - {1'b0, source_register} - {8'h00, carryIn}; // RQ2 RQ12
	assign addOvf = (destVal[7] == source_register[7]) && (addSum[7] != destVal[7]);
	assign subOvf = (destVal[7] != source_register[7]) && (subDiff[7] != destVal[7]);

	// Logic unit
	logic [7:0] logicRes;

	assign logicRes = (op == abeu_pkg::OP_AND) ? (destVal & source_register) // RQ4
		: (op == abeu_pkg::OP_OR) ? (destVal | source_register) // RQ4
		: (op == abeu_pkg::OP_XOR) ? (destVal ^ source_register) // RQ4
		: (op == abeu_pkg::OP_SET_BITS) ? (destVal | source_register) // RQ5
		: (op == abeu_pkg::OP_CLEAR_BITS) ? (destVal & (abeu_pkg::MASK_ALL - source_register)) // RQ5
		: (destVal & destVal); // RQ6

	// Byte result and its flags
	logic [7:0] byteRes;
	logic byteZero;
	logic byteNeg;
	logic byteOvf;

	assign byteRes = isAdd ? addSum[7:0] : isSubLike ? subDiff[7:0] : logicRes;
	assign byteZero = (byteRes == 8'h00) & (~chainZero | statusFf[abeu_pkg::FLAG_Z]);
	assign byteNeg = byteRes[7];
	// Logic operations always clear overflow
	assign byteOvf = isAdd ? addOvf : isSubLike ? subOvf : 1'b0; // RQ4

	// Word unit: six-bit constant on a register pair
	logic [16:0] wordSum;
	logic [16:0] wordDiff;
	logic wordMinus;
	logic [15:0] wordRes;
	logic wordCarry;
	logic wordOvf;

	assign wordMinus = (op == abeu_pkg::OP_WORD_MINUS_IMM);
	assign wordSum = {1'b0, pairVal} + {11'h000, source_register[5:0]}; // RQ3
	assign wordDiff = {1'b0, pairVal} - {11'h000, source_register[5:0]}; // RQ3
	assign wordRes = wordMinus ? wordDiff[15:0] : wordSum[15:0];
	assign wordCarry = wordMinus ? wordDiff[16] : wordSum[16];
	assign wordOvf = wordMinus ? (pairVal[15] & ~wordRes[15]) : (~pairVal[15] & wordRes[15]);

	// Multiplier
	assign mulBus.mulA = destVal;
	assign mulBus.mulB = source_register;
	assign mulBus.signedA = (op == abeu_pkg::OP_PROD_S) || (op == abeu_pkg::OP_PROD_SU)
		|| (op == abeu_pkg::OP_FRAC_S) || (op == abeu_pkg::OP_FRAC_SU);
	assign mulBus.signedB = (op == abeu_pkg::OP_PROD_S) || (op == abeu_pkg::OP_FRAC_S);
	assign mulBus.fraction = (op == abeu_pkg::OP_FRAC_U) || (op == abeu_pkg::OP_FRAC_S)
		|| (op == abeu_pkg::OP_FRAC_SU);

	abeu_multiplier u_mul (
		.mul(mulBus.multiplier)
	);

	// Branch condition; the signed bit is formed live from N and V
	logic flagPicked;
	logic branchTaken;

	assign flagPicked = (bitSel == abeu_pkg::FLAG_S)
		? (statusFf[abeu_pkg::FLAG_N] ^ statusFf[abeu_pkg::FLAG_V]) // RQ16
		: statusFf[bitSel]; // RQ15 RQ17 RQ18 RQ19 RQ20 RQ21
	assign branchTaken = (op == abeu_pkg::OP_BRANCH_SET) ? flagPicked : ~flagPicked; // RQ15

	// Skip condition
	logic skipTaken;

	assign skipTaken = (op == abeu_pkg::OP_SKIP_EQUAL) ? (destVal == source_register) // RQ11
		: (op == abeu_pkg::OP_SKIP_REG_CLR) ? ~destVal[bitSel] // RQ13
		: (op == abeu_pkg::OP_SKIP_REG_SET) ? destVal[bitSel] // RQ13
		: (op == abeu_pkg::OP_SKIP_IO_CLR) ? ~ioByte[bitSel] // RQ14
		: ioByte[bitSel]; // RQ14

	// Targets and cycle counts
	logic [15:0] offsetExt;
	logic [15:0] branchTarget;
	logic [15:0] skipTarget;
	logic flowLoad;
	logic [15:0] flowTarget;
	logic [1:0] opCycles;

	assign offsetExt = {{9{branchOffset[6]}}, branchOffset};
	assign branchTarget = pcIn + offsetExt + abeu_pkg::PC_STEP; // RQ15
	assign skipTarget = pcIn + (nextIsTwoWords ? abeu_pkg::SKIP_LONG : abeu_pkg::SKIP_SHORT); // RQ11
	assign flowLoad = (op == abeu_pkg::OP_JUMP_PTR) || (op == abeu_pkg::OP_CALL_PTR)
		|| (isBranch & branchTaken) || (isSkip & skipTaken);
	assign flowTarget = isBranch ? branchTarget : isSkip ? skipTarget : zPointer; // RQ9 RQ10
	assign opCycles = (op == abeu_pkg::OP_CALL_PTR) ? abeu_pkg::CYC_THREE // RQ10
		: ((op == abeu_pkg::OP_JUMP_PTR) || isWord || isMul) ? abeu_pkg::CYC_TWO // RQ3 RQ7 RQ9
		: isBranch ? (branchTaken ? abeu_pkg::CYC_TWO : abeu_pkg::CYC_ONE) // RQ22
		: (isSkip & skipTaken) ? (nextIsTwoWords ? abeu_pkg::CYC_THREE : abeu_pkg::CYC_TWO) // RQ22
		: abeu_pkg::CYC_ONE;

	// Next status: each class touches only its own flags
	logic [7:0] arithStatus;
	logic [7:0] logicStatus;
	logic [7:0] wordStatus;
	logic [7:0] mulStatus;

	always_comb begin
		arithStatus = statusFf;
		arithStatus[abeu_pkg::FLAG_C] = isAdd ? addSum[8] : subDiff[8]; // RQ1 RQ2 RQ12
		arithStatus[abeu_pkg::FLAG_H] = isAdd ? addNib[4] : subNib[4];
		arithStatus[abeu_pkg::FLAG_Z] = byteZero;
		arithStatus[abeu_pkg::FLAG_N] = byteNeg;
		arithStatus[abeu_pkg::FLAG_V] = byteOvf;
		arithStatus[abeu_pkg::FLAG_S] = byteNeg ^ byteOvf;
		logicStatus = statusFf; // RQ4
		logicStatus[abeu_pkg::FLAG_Z] = byteZero; // RQ5 RQ6
		logicStatus[abeu_pkg::FLAG_N] = byteNeg;
		logicStatus[abeu_pkg::FLAG_V] = 1'b0;
		logicStatus[abeu_pkg::FLAG_S] = byteNeg;
		wordStatus = statusFf;
		wordStatus[abeu_pkg::FLAG_C] = wordCarry; // RQ3
		wordStatus[abeu_pkg::FLAG_Z] = (wordRes == 16'h0000);
		wordStatus[abeu_pkg::FLAG_N] = wordRes[15];
		wordStatus[abeu_pkg::FLAG_V] = wordOvf;
		wordStatus[abeu_pkg::FLAG_S] = wordRes[15] ^ wordOvf;
		mulStatus = statusFf;
		mulStatus[abeu_pkg::FLAG_C] = mulBus.productCarry; // RQ7 RQ8
		mulStatus[abeu_pkg::FLAG_Z] = mulBus.productZero;
	end

	// Flow operations leave the status untouched
	assign nxt_status = !take ? (flagLoad ? flagLoadVal : statusFf)
		: (isAdd | isSubLike) ? arithStatus
		: isLogic ? logicStatus
		: isWord ? wordStatus
		: isMul ? mulStatus
		: statusFf; // RQ9 RQ10 RQ11 RQ14 RQ15

	// Sequencer: an operation holds the unit for its whole cycle count
	assign ready = (remFf == 2'h0);
	assign take = start & ready;
	assign nxt_rem = take ? (opCycles - abeu_pkg::CYC_ONE) : ready ? 2'h0 : (remFf - 2'h1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remFf <= 2'h0;
			doneFf <= 1'b0;
			statusFf <= abeu_pkg::STATUS_RESET;
		end else begin
			remFf <= nxt_rem;
			doneFf <= take ? (opCycles == abeu_pkg::CYC_ONE) : (remFf == 2'h1); // RQ22
			statusFf <= nxt_status;
		end
	end

	// Results are caught at the take edge and held until the next take
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			byteWrFf <= 1'b0;
			pairWrFf <= 1'b0;
			prodDestFf <= 1'b0;
			pcLoadFf <= 1'b0;
			pushFf <= 1'b0;
			byteResFf <= 8'h00;
			pairResFf <= 16'h0000;
			pcTargetFf <= 16'h0000;
			returnAddrFf <= 16'h0000;
		end else if (take) begin
			byteWrFf <= isAdd | (isSubLike & ~isCompare) | isLogic; // RQ12
			pairWrFf <= isWord | isMul; // RQ3 RQ7
			prodDestFf <= isMul; // RQ7
			pcLoadFf <= flowLoad; // RQ9 RQ11 RQ15
			pushFf <= (op == abeu_pkg::OP_CALL_PTR); // RQ10
			byteResFf <= byteRes;
			pairResFf <= isMul ? mulBus.product : wordRes;
			pcTargetFf <= flowTarget;
			returnAddrFf <= pcIn + abeu_pkg::PC_STEP; // RQ10
		end
	end

	// Strobes fire in the completion cycle only
	assign done = doneFf;
	assign byteWrite = doneFf & byteWrFf;
	assign pairWrite = doneFf & pairWrFf;
	assign pairToProduct = prodDestFf;
	assign pcLoad = doneFf & pcLoadFf;
	assign pushReturn = doneFf & pushFf;
	assign byteResult = byteResFf;
	assign pairResult = pairResFf;
	assign pcTarget = pcTargetFf;
	assign returnAddr = returnAddrFf;
	assign status_flags_register = statusFf;
endmodule : abeu_exec_unit

// ---- bench/abeu_regfile_model.sv ----
`timescale 1ns/1ps
module abeu_regfile_model (
	// Clock
	input wire logic clk,
	// Write-back from the unit
	input wire logic byteWrite,
	input wire logic [7:0] byteResult,
	input wire logic pairWrite,
	input wire logic pairToProduct,
	input wire logic [15:0] pairResult,
	// Stored register contents
	output logic [7:0] destReg,
	output logic [15:0] productPair,
	output logic [15:0] wordPair
);
	// Register file stores on the strobe edge only, so a stuck strobe shows up as a stale pair
	always_ff @(posedge clk) begin
		if (byteWrite) destReg <= byteResult;
		if (pairWrite && pairToProduct) productPair <= pairResult;
		if (pairWrite && !pairToProduct) wordPair <= pairResult;
	end
endmodule : abeu_regfile_model

// ---- bench/abeu_exec_unit_properties.sv ----
`timescale 1ns/1ps
module abeu_exec_checker (
	// Watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire abeu_pkg::abeu_op_t op,
	input wire logic [2:0] bitSel,
	input wire logic [6:0] branchOffset,
	input wire logic [15:0] pcIn,
	input wire logic [15:0] zPointer,
	input wire logic ready,
	input wire logic done,
	input wire logic pairWrite,
	input wire logic pcLoad,
	input wire logic [15:0] pcTarget,
	input wire logic pushReturn,
	input wire logic [15:0] returnAddr,
	input wire logic [7:0] status_flags_register
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire take = start && ready;
	wire logicOp = op inside {[abeu_pkg::OP_AND:abeu_pkg::OP_ZERO_SIGN_TEST]};
	wire cmpOp = op inside {[abeu_pkg::OP_COMPARE:abeu_pkg::OP_COMPARE_BORROW]};
	wire oneCyc = op < abeu_pkg::OP_WORD_PLUS_IMM || logicOp || cmpOp;
	wire mulOp = op inside {[abeu_pkg::OP_PROD_U:abeu_pkg::OP_FRAC_SU]};
	wire flowOp = op >= abeu_pkg::OP_JUMP_PTR && !cmpOp;
	wire flagNow = status_flags_register[bitSel];
	wire [15:0] brTarget = pcIn + {{9{branchOffset[6]}}, branchOffset} + 16'h0001;
	a_one_cycle_alu: assert property (take && oneCyc |=> done && ready)
		else $error("single-cycle operation not finished after one cycle");
	a_logic_keeps_ch: assert property (take && logicOp |=>
		status_flags_register[0] == $past(status_flags_register[0])
		&& status_flags_register[5] == $past(status_flags_register[5]))
		else $error("logic operation changed carry or half-carry");
	a_product_two_cyc: assert property (take && mulOp |=> !done ##1 (done && pairWrite))
		else $error("multiply did not write its pair after two cycles");
	a_jump_to_pointer: assert property (take && op == abeu_pkg::OP_JUMP_PTR |=> !done ##1
		(done && pcLoad && pcTarget == $past(zPointer, 2))) else $error("pointer jump target or timing wrong");
	a_call_three_cyc: assert property (take && op == abeu_pkg::OP_CALL_PTR |=> !ready [*2] ##1
		(done && pushReturn && returnAddr == $past(pcIn, 3) + 16'h0001)) else $error("pointer call wrong");
	a_flow_keeps_flags: assert property (take && flowOp |=> $stable(status_flags_register))
		else $error("control-flow operation changed the status");
	a_branch_not_taken: assert property (take && op == abeu_pkg::OP_BRANCH_SET && bitSel != 3'h4
		&& !flagNow |=> done && !pcLoad)
		else $error("untaken branch loaded the program counter or took too long");
	a_branch_taken_tgt: assert property (take && op == abeu_pkg::OP_BRANCH_CLR && bitSel != 3'h4
		&& !flagNow |=> !done ##1 (done && pcLoad && pcTarget == $past(brTarget, 2)))
		else $error("taken branch target or timing wrong");
	c_call: cover property (take && op == abeu_pkg::OP_CALL_PTR);
	c_taken: cover property (pcLoad && !pushReturn);
	c_product: cover property (done && pairWrite);
endmodule : abeu_exec_checker
bind abeu_exec_unit abeu_exec_checker abeu_exec_checker_inst (.clk, .rst, .start, .op, .bitSel, .branchOffset,
	.pcIn, .zPointer, .ready, .done, .pairWrite, .pcLoad, .pcTarget, .pushReturn, .returnAddr,
	.status_flags_register);

// ---- bench/alu_branch_execute_unit_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module alu_branch_execute_unit_tb;
	logic clk = 1'b0, rst = 1'b1, start = 1'b0, nextIsTwoWords = 1'b0, flagLoad = 1'b0;
	abeu_pkg::abeu_op_t op = abeu_pkg::OP_ADD, o;
	logic [7:0] destVal = 8'h00, source_register = 8'h00, ioByte = 8'h00, flagLoadVal = 8'h00;
	logic [15:0] pairVal = 16'h0000, pcIn = 16'h0000, zPointer = 16'h0000, cv;
	logic [2:0] bitSel = 3'h0;
	logic [6:0] branchOffset = 7'h00;
	logic ready, done, byteWrite, pairWrite, pairToProduct, pcLoad, pushReturn;
	logic [7:0] byteResult, status_flags_register, destReg, st;
	logic [15:0] pairResult, pcTarget, returnAddr, productPair, wordPair;
	logic [31:0] seed = 32'h5032380B;
	int err_count = 0, num_checks = 0;
	abeu_pkg::abeu_op_t cornerOp [6] = '{abeu_pkg::OP_ADD, abeu_pkg::OP_SUB, abeu_pkg::OP_WORD_PLUS_IMM,
		abeu_pkg::OP_FRAC_S, abeu_pkg::OP_CLEAR_BITS, abeu_pkg::OP_SKIP_EQUAL};
	logic [15:0] cornerVal [6] = '{16'hFF01, 16'h8001, 16'hFF01, 16'h8080, 16'hF0F0, 16'h5A5A};
	abeu_exec_unit abeu_exec_unit_inst (.clk, .rst, .start, .op, .destVal, .source_register, .pairVal, .bitSel,
		.ioByte, .branchOffset, .nextIsTwoWords, .pcIn, .zPointer, .flagLoad, .flagLoadVal, .ready, .done,
		.byteWrite, .byteResult, .pairWrite, .pairToProduct, .pairResult, .pcLoad, .pcTarget, .pushReturn,
		.returnAddr, .status_flags_register);
	abeu_regfile_model abeu_regfile_model_inst (.clk, .byteWrite, .byteResult, .pairWrite, .pairToProduct,
		.pairResult, .destReg, .productPair, .wordPair);
	initial begin
		forever #10 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [15:0] exp_product(abeu_pkg::abeu_op_t k, logic [7:0] a, logic [7:0] b);
		logic sa, sb;
		// Low 16 bits of the extended product are exact for every signedness mix
		sa = a[7] & !(k inside {abeu_pkg::OP_PROD_U, abeu_pkg::OP_FRAC_U});
		sb = b[7] & (k inside {abeu_pkg::OP_PROD_S, abeu_pkg::OP_FRAC_S});
		return {{8{sa}}, a} * {{8{sb}}, b};
	endfunction : exp_product
	function automatic logic exp_flag(logic [7:0] s, logic [2:0] b);
		return (b == 3'h4) ? s[2] ^ s[3] : s[b];
	endfunction : exp_flag
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic run();
		logic [8:0] r;
		logic [15:0] w, p, tgt;
		logic [7:0] e, res;
		logic ad, bo, ci, v, tk, wr, f;
		int cyc, n;
		start <= 1'b1;
		op <= o;
		@(posedge clk);
		start <= 1'b0;
		{e, cyc, tk, wr, res, w} = {st, 32'd1, 2'b00, 8'h00, 16'h0000};
		tgt = pcIn + {{9{branchOffset[6]}}, branchOffset} + 16'h0001;
		ad = o inside {abeu_pkg::OP_ADD, abeu_pkg::OP_ADD_CARRY, abeu_pkg::OP_WORD_PLUS_IMM};
		bo = o inside {abeu_pkg::OP_SUB_BORROW, abeu_pkg::OP_COMPARE_BORROW};
		ci = st[0] & (bo || o == abeu_pkg::OP_ADD_CARRY);
		case (o) inside
			[abeu_pkg::OP_ADD:abeu_pkg::OP_SUB_BORROW], [abeu_pkg::OP_COMPARE:abeu_pkg::OP_COMPARE_BORROW]: begin
				r = ad ? {1'b0, destVal} + source_register + ci : {1'b0, destVal} - source_register - ci;
				v = (destVal[7] == (source_register[7] ^ !ad)) && (r[7] != destVal[7]);
				res = r[7:0];
				wr = o < abeu_pkg::OP_COMPARE;
				// Borrow forms keep zero only if it was already set, so multi-byte compares chain
				e[5:0] = {destVal[4] ^ source_register[4] ^ r[4], r[7] ^ v, v, r[7], res == 8'h00 && (!bo || st[1]), r[8]};
			end
			[abeu_pkg::OP_AND:abeu_pkg::OP_ZERO_SIGN_TEST]: begin
				case (o)
					abeu_pkg::OP_AND: res = destVal & source_register;
					abeu_pkg::OP_XOR: res = destVal ^ source_register;
					abeu_pkg::OP_CLEAR_BITS: res = destVal & (8'hFF - source_register);
					abeu_pkg::OP_ZERO_SIGN_TEST: res = destVal & destVal;
					default: res = destVal | source_register;
				endcase
				wr = 1'b1;
				e[4:1] = {res[7], 1'b0, res[7], res == 8'h00};
			end
			abeu_pkg::OP_WORD_PLUS_IMM, abeu_pkg::OP_WORD_MINUS_IMM: begin
				w = ad ? pairVal + source_register[5:0] : pairVal - source_register[5:0];
				v = ad ? !pairVal[15] & w[15] : pairVal[15] & !w[15];
				e[4:0] = {w[15] ^ v, v, w[15], w == 16'h0000, ad ? pairVal[15] & !w[15] : w[15] & !pairVal[15]};
				cyc = 2;
			end
			[abeu_pkg::OP_PROD_U:abeu_pkg::OP_FRAC_SU]: begin
				p = exp_product(o, destVal, source_register);
				w = (o >= abeu_pkg::OP_FRAC_U) ? p << 1 : p;
				e[1:0] = {w == 16'h0000, p[15]};
				cyc = 2;
			end
			abeu_pkg::OP_JUMP_PTR, abeu_pkg::OP_CALL_PTR: begin
				tk = 1'b1;
				tgt = zPointer;
				cyc = (o == abeu_pkg::OP_CALL_PTR) ? 3 : 2;
			end
			[abeu_pkg::OP_SKIP_REG_CLR:abeu_pkg::OP_SKIP_IO_SET], abeu_pkg::OP_SKIP_EQUAL: begin
				f = (o < abeu_pkg::OP_SKIP_IO_CLR) ? destVal[bitSel] : ioByte[bitSel];
				tk = (o == abeu_pkg::OP_SKIP_EQUAL) ? destVal == source_register
					: f == (o inside {abeu_pkg::OP_SKIP_REG_SET, abeu_pkg::OP_SKIP_IO_SET});
				tgt = pcIn + (nextIsTwoWords ? 16'h0003 : 16'h0002);
				cyc = tk ? 2 + nextIsTwoWords : 1;
			end
			default: begin
				f = exp_flag(st, bitSel);
				tk = f == (o == abeu_pkg::OP_BRANCH_SET);
				cyc = tk ? 2 : 1;
			end
		endcase
		n = 0;
		do begin
			#1;
			n++;
			if (done !== 1'b1 && n < 4) @(posedge clk);
		end while (done !== 1'b1 && n < 4);
		`CHK("cycles", cyc, n)
		`CHK("status", e, status_flags_register)
		`CHK("byteWrite", wr, byteWrite)
		if (wr) `CHK("byteResult", res, byteResult)
		`CHK("pcLoad", tk, pcLoad)
		if (tk) `CHK("pcTarget", tgt, pcTarget)
		`CHK("pushReturn", o == abeu_pkg::OP_CALL_PTR, pushReturn)
		if (o == abeu_pkg::OP_CALL_PTR) `CHK("returnAddr", pcIn + 16'h0001, returnAddr)
		if (cyc == 2 && !tk) `CHK("pairToProduct", o >= abeu_pkg::OP_PROD_U, pairToProduct)
		if (wr || (cyc == 2 && !tk)) begin
			@(posedge clk);
			#1;
			if (wr) `CHK("destReg", res, destReg)
			else `CHK("pair", w, (o >= abeu_pkg::OP_PROD_U) ? productPair : wordPair)
		end
		st = e;
	endtask : run
	initial begin
		st = abeu_pkg::STATUS_RESET;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK("ready", 1'b1, ready)
		`CHK("status", abeu_pkg::STATUS_RESET, status_flags_register)
		for (int i = 0; i < 400; i++) begin
			@(posedge clk);
			if (i % 8 == 7) begin
				// Random T and I bits let both branch senses on every flag come up
				st = 8'(rnd());
				flagLoad <= 1'b1;
				flagLoadVal <= st;
				@(posedge clk);
				flagLoad <= 1'b0;
			end
			cv = (i < 6) ? cornerVal[i] : 16'(rnd());
			o = (i < 6) ? cornerOp[i] : abeu_pkg::abeu_op_t'(5'(rnd() % 29));
			destVal <= cv[15:8];
			source_register <= cv[7:0];
			pairVal <= (i < 6) ? {cv[15:8], cv[15:8]} : 16'(rnd());
			{ioByte, bitSel, branchOffset, nextIsTwoWords} <= 19'(rnd());
			{pcIn, zPointer} <= rnd();
			run();
		end
		tally_and_finish();
	end
	initial begin
		// 400 operations of at most three cycles plus loads, with ample slack
		#200000;
		err_count++;
		tally_and_finish();
	end
endmodule : alu_branch_execute_unit_tb
